// ==== include/mass_pkg.sv ====
package mass_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CLK_KHZ = 40000;
  localparam int OTB_DELAY_MS = 2;
  localparam int OTB_CYCLES = OTB_DELAY_MS * CLK_KHZ;
  localparam int PGH_DELAY_NS = 100;
  localparam int PGH_CYCLES = (PGH_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 17;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam int STAT_ST_LSB = 0;
  localparam int STAT_LOSS_BIT = 8;
  localparam int STAT_ON_BIT = 9;
  localparam logic CTRL_ON_RST = 1'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_OFF = 4'b0000,
    ST_CORE = 4'b0001,
    ST_OFFSET = 4'b0010,
    ST_OTB = 4'b0011,
    ST_BIAS = 4'b0100,
    ST_GBIAS = 4'b0101,
    ST_ON = 4'b0110,
    ST_PARK = 4'b0111,
    ST_HOLD = 4'b1000,
    ST_DISCH = 4'b1001,
    ST_EMERG = 4'b1010
  } mass_state_t;
endpackage : mass_pkg

// ==== test/mass_partner.sv ====
`timescale 1ns/1ps
module mass_partner (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic power_loss,
  input wire logic core_supply_en,
  input wire logic interface_supply_en,
  input wire logic offset_supply_en,
  input wire logic bias_supply_en,
  input wire logic mirror_reset_supply_en,
  input wire logic park_req,
  output logic core_supply_good,
  output logic interface_supply_good,
  output logic offset_power_good,
  output logic bias_supply_good,
  output logic mirror_reset_supply_good,
  output logic supplies_discharged,
  output logic park_done
);
  logic [3:0] core_cnt, ofs_cnt, rail_cnt, dis_cnt, park_cnt, hold_cnt, loss_cnt;
  logic [3:0] dly;
  assign dly = slow ? 4'h8 : 4'h2;
  assign core_supply_good = core_cnt >= dly;
  assign interface_supply_good = core_cnt >= dly;
  // bias and reset rails share one settle counter, each good gated by its own enable; no order between them
  assign bias_supply_good = bias_supply_en && (rail_cnt >= dly);
  assign mirror_reset_supply_good = mirror_reset_supply_en && (rail_cnt >= dly);
  // near ground only after all three rails are off for a while
  assign supplies_discharged = (dis_cnt >= dly) && !offset_power_good;
  assign park_done = park_req && (park_cnt >= dly);
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      {core_cnt, ofs_cnt, rail_cnt, dis_cnt} <= 16'h0000;
      {park_cnt, hold_cnt, loss_cnt} <= 12'h000;
      offset_power_good <= 1'b0;
    end
    else
    begin
      core_cnt <= (core_supply_en && interface_supply_en) ? core_cnt + 4'(core_cnt != 4'hf) : 4'h0;
      ofs_cnt <= offset_supply_en ? ofs_cnt + 4'(ofs_cnt != 4'hf) : 4'h0;
      rail_cnt <= (bias_supply_en || mirror_reset_supply_en) ? rail_cnt + 4'(rail_cnt != 4'hf) : 4'h0;
      dis_cnt <= !(offset_supply_en || bias_supply_en || mirror_reset_supply_en) ?
                 dis_cnt + 4'(dis_cnt != 4'hf) : 4'h0;
      park_cnt <= park_req ? park_cnt + 4'(park_cnt != 4'hf) : 4'h0;
      hold_cnt <= !offset_supply_en ? hold_cnt + 4'(hold_cnt != 4'hf) : 4'h0;
      loss_cnt <= power_loss ? loss_cnt + 4'(loss_cnt != 4'hf) : 4'h0;
      if (loss_cnt >= 4'h6)
        offset_power_good <= 1'b0; // rail collapses under loss
      else if (offset_supply_en && ofs_cnt >= dly)
        offset_power_good <= 1'b1;
      else if (!offset_supply_en && hold_cnt >= 4'h5)
        offset_power_good <= 1'b0; // held 150 ns past enable fall
    end
endmodule : mass_partner

// ==== test/test_mass_seq.sv ====
`timescale 1ns/1ps
module test_mass_seq;
  import mass_pkg::*;
  localparam logic [TMR_W-1:0] OTB = 17'h00008;
  logic sys_clk, rst_b, slow, power_loss;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rnd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic core_g, intf_g, pg, bias_g, rst_g, disch, park_done;
  logic core_en, intf_en, ofs_en, bias_en, rst_en, cmos_en, pdn, oe_n, gbias, park_req;
  logic core_q, bias_q, pg_q, oe_q, gb_q, park_seen;
  int err_count, compares, gb_cnt, pg_cnt;
  logic [33:0] rq[$];
  logic [1:0] wq[$];

  mass_seq #(.OTB_LOAD(OTB)) i_mass_seq (.sys_clk(sys_clk), .rst_b(rst_b),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .core_supply_good(core_g), .interface_supply_good(intf_g), .offset_power_good(pg),
    .bias_supply_good(bias_g), .mirror_reset_supply_good(rst_g),
    .supplies_discharged(disch), .park_done(park_done), .power_loss(power_loss),
    .core_supply_en(core_en), .interface_supply_en(intf_en), .offset_supply_en(ofs_en),
    .bias_supply_en(bias_en), .mirror_reset_supply_en(rst_en), .cmos_inputs_en(cmos_en),
    .power_down_n(pdn), .mirror_output_enable_n(oe_n), .global_bias_cmd(gbias),
    .park_req(park_req));

  mass_partner i_mass_partner (.sys_clk(sys_clk), .rst_b(rst_b), .slow(slow),
    .power_loss(power_loss), .core_supply_en(core_en), .interface_supply_en(intf_en),
    .offset_supply_en(ofs_en), .bias_supply_en(bias_en), .mirror_reset_supply_en(rst_en),
    .park_req(park_req), .core_supply_good(core_g), .interface_supply_good(intf_g),
    .offset_power_good(pg), .bias_supply_good(bias_g), .mirror_reset_supply_good(rst_g),
    .supplies_discharged(disch), .park_done(park_done));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic aw_d, w_d;
    wq.push_back(er);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= s; bready <= 1'b1;
    aw_d = 1'b0; w_d = 1'b0;
    while (!(aw_d && w_d))
    begin
      @(posedge sys_clk);
      if (awready && !aw_d) begin aw_d = 1'b1; awvalid <= 1'b0; end
      if (wready && !w_d) begin w_d = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge sys_clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
    rq.push_back({er, ed});
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask : axi_rd

  task automatic power_up;
    rnd = lfsr(rnd);
    slow <= rnd[0];
    axi_wr(CTRL_OFS, {rnd[31:2], 2'b01}, 4'hf, RESP_OKAY);
    while (oe_n !== 1'b0) @(posedge sys_clk);
    chk(gb_cnt == 1, "one bias command per power-up");
    gb_cnt = 0;
    axi_rd(STATUS_OFS, RESP_OKAY, 32'h0000_0206);
  endtask : power_up

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // response checker and port watcher
  always @(posedge sys_clk)
  begin
    if (rvalid && rready)
      chk(rq.size() > 0 && {rresp, rdata} === rq.pop_front(), "read response");
    if (bvalid && bready)
      chk(wq.size() > 0 && bresp === wq.pop_front(), "write response");
    if (rst_b)
    begin
      if (!core_q && core_en) chk(oe_n === 1'b1, "rails on with mirrors enabled");
      if (ofs_en || bias_en || rst_en || cmos_en)
        chk(core_g && intf_g, "rail or cmos before core settled");
      if (!bias_q && bias_en) chk(pg_cnt >= OTB, "bias too soon after offset good");
      if (bias_q && !bias_en && !power_loss) chk(park_seen, "rails dropped unparked");
      if (core_q && !core_en) chk(disch && !ofs_en && !bias_en, "core off too soon");
      if (pg_q && !pg && power_loss) chk(oe_q === 1'b1, "mirrors live at loss");
      if (gbias) chk(bias_g && rst_g && !gb_q, "bias command timing");
      if (bias_en || rst_en) chk(bias_en === rst_en, "bias and reset rails split");
    end
    if (gbias) gb_cnt++;
    pg_cnt = pg ? pg_cnt + 1 : 0;
    if (park_done && park_req) park_seen = 1'b1;
    if (!core_q && core_en) park_seen = 1'b0;
    {core_q, bias_q, pg_q, oe_q, gb_q} = {core_en, bias_en, pg, oe_n, gbias};
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    give_verdict();
  end

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, slow, power_loss} = 7'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    rst_b = 1'b0;
    rnd = 32'hd165;
    err_count = 0; compares = 0; gb_cnt = 0; pg_cnt = 0; park_seen = 1'b0;
    repeat (20) @(posedge sys_clk);
    chk({core_en, intf_en, ofs_en, bias_en, rst_en, cmos_en, pdn, oe_n} === 8'h01,
        "outputs in reset");
    rst_b <= 1'b1;
    @(posedge sys_clk);
    axi_rd(STATUS_OFS, RESP_OKAY, 32'h0);
    axi_rd(8'h08, RESP_SLVERR, 32'h0);
    axi_rd(8'h01, RESP_SLVERR, 32'h0);
    axi_wr(8'h0c, 32'h1, 4'hf, RESP_SLVERR);
    axi_wr(CTRL_OFS, 32'h1, 4'he, RESP_OKAY);
    axi_wr(STATUS_OFS, 32'hffff_ffff, 4'hf, RESP_OKAY);
    axi_rd(CTRL_OFS, RESP_OKAY, 32'h0);
    axi_rd(STATUS_OFS, RESP_OKAY, 32'h0);
    // abort during ramp: straight to hold, no park and no bias command
    axi_wr(CTRL_OFS, 32'h1, 4'h1, RESP_OKAY);
    axi_wr(CTRL_OFS, 32'h0, 4'h1, RESP_OKAY);
    while (core_en !== 1'b0) @(posedge sys_clk);
    chk(!park_seen && gb_cnt == 0, "ramp abort parked or biased");
    axi_rd(STATUS_OFS, RESP_OKAY, 32'h0);
    power_up();
    axi_rd(CTRL_OFS, RESP_OKAY, 32'h1);
    // normal shutdown through park and hold
    axi_wr(CTRL_OFS, 32'h0, 4'h1, RESP_OKAY);
    while (core_en !== 1'b0) @(posedge sys_clk);
    chk(park_seen, "shutdown without park");
    axi_rd(STATUS_OFS, RESP_OKAY, 32'h0);
    // loss while running
    power_up();
    power_loss <= 1'b1;
    while (core_en !== 1'b0) @(posedge sys_clk);
    power_loss <= 1'b0;
    axi_rd(STATUS_OFS, RESP_OKAY, 32'h0000_0100);
    axi_rd(CTRL_OFS, RESP_OKAY, 32'h0);
    axi_wr(CTRL_OFS, 32'h2, 4'h1, RESP_OKAY);
    axi_rd(STATUS_OFS, RESP_OKAY, 32'h0);
    give_verdict();
  end
endmodule : test_mass_seq

// ==== verilog/mass_axil.sv ====
`timescale 1ns/1ps
module mass_axil
  import mass_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic rd_err
);
  logic rd_pend;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid, next_rd_pend;
  logic [1:0] next_bresp, next_rresp;
  logic [ADDR_W-1:0] next_wr_addr, next_rd_addr;
  logic [DATA_W-1:0] next_wr_data, next_rdata;
  logic [3:0] next_wr_strb;

  // both halves held and no answer pending: exactly one write per pair
  assign wr_en = !awready && !wready && !bvalid;

  always_comb
  begin
    next_awready = awready;
    next_wready = wready;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_arready = arready;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_rd_addr = rd_addr;
    next_rd_pend = rd_pend;
    if (awvalid && awready)
    begin
      next_awready = 1'b0;
      next_wr_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_wready = 1'b0;
      next_wr_data = wdata;
      next_wr_strb = wstrb;
    end
    if (wr_en)
    begin
      next_bvalid = 1'b1;
      next_bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (bvalid && bready)
    begin
      next_bvalid = 1'b0;
      next_awready = 1'b1;
      next_wready = 1'b1;
    end
    if (arvalid && arready)
    begin
      next_arready = 1'b0;
      next_rd_addr = araddr;
      next_rd_pend = 1'b1;
    end
    if (rd_pend)
    begin
      next_rd_pend = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = rd_data;
      next_rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (rvalid && rready)
    begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= '0;
      rd_addr <= '0;
      rd_pend <= 1'b0;
    end
    else
    begin
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      rd_addr <= next_rd_addr;
      rd_pend <= next_rd_pend;
    end
  end
endmodule : mass_axil

// ==== verilog/mass_seq.sv ====
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
// Overview of operation
// RULE_01: core and interface rails up and settled before offset, bias or reset rails.
// RULE_02: bias and reset rails wait at least the offset-to-bias delay after offset good.
// RULE_03: bias and mirror-reset rails need no order between them.
// RULE_04: cmos inputs stay low until core and interface rails have settled.
// RULE_05: core and interface rails stay on until the other rails are discharged.
// RULE_06: offset good must hold 100 ns after offset enable falls in normal shutdown.
// RULE_07: rails are enabled only while mirror output enable is high (inactive).
// RULE_08: once rails are up a global bias command completes power-up.
// RULE_09: shutdown parks mirrors first, then asserts power-down and drops three rails.
// RULE_10: on power loss, output enable goes high first; offset enable may follow good.
// RULE_11: start all off with power-down asserted; advance only on good flags and timers.
module mass_seq
  import mass_pkg::*;
#(
  parameter logic [TMR_W-1:0] OTB_LOAD = TMR_W'(OTB_CYCLES)
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic core_supply_good,
  input wire logic interface_supply_good,
  input wire logic offset_power_good,
  input wire logic bias_supply_good,
  input wire logic mirror_reset_supply_good,
  input wire logic supplies_discharged,
  input wire logic park_done,
  input wire logic power_loss,
  output logic core_supply_en,
  output logic interface_supply_en,
  output logic offset_supply_en,
  output logic bias_supply_en,
  output logic mirror_reset_supply_en,
  output logic cmos_inputs_en,
  output logic power_down_n,
  output logic mirror_output_enable_n,
  output logic global_bias_cmd,
  output logic park_req
);
  localparam logic [TMR_W-1:0] PGH_LOAD = TMR_W'(PGH_CYCLES);
  localparam logic [TMR_W-1:0] OG_ONE = TMR_W'(1);

  mass_state_t state, next_state;
  logic power_on, loss_seen, next_power_on, next_loss;
  logic next_core, next_cmos, next_offset, next_bias, next_pdn, next_oen;
  logic next_gbias, next_park;
  logic otb_start, otb_done, hold_start, hold_done;
  logic wr_en, wr_err, rd_err;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic [3:0] wr_strb;
  logic [TMR_W-1:0] og_cnt, next_og_cnt;

  mass_axil u_axil (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .awaddr(s_axi_awaddr),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .bresp(s_axi_bresp),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .araddr(s_axi_araddr),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  mass_timer #(.W(TMR_W)) u_otb_timer (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .start(otb_start),
    .load(OTB_LOAD),
    .done(otb_done)
  );

  mass_timer #(.W(TMR_W)) u_hold_timer (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .start(hold_start),
    .load(PGH_LOAD),
    .done(hold_done)
  );

  always_comb
  begin
    next_state = state;
    case (state)
      ST_OFF:
        if (power_on && !power_loss && mirror_output_enable_n)
          next_state = ST_CORE; // [RULE_07] [RULE_11]
      ST_CORE:
        if (core_supply_good && interface_supply_good)
          next_state = ST_OFFSET; // [RULE_01] [RULE_04]
      ST_OFFSET:
        if (offset_power_good)
          next_state = ST_OTB;
      ST_OTB:
        // a dropped offset good restarts the whole delay
        if (!offset_power_good)
          next_state = ST_OFFSET;
        else if (otb_done)
          next_state = ST_BIAS; // [RULE_02]
      ST_BIAS:
        if (bias_supply_good && mirror_reset_supply_good)
          next_state = ST_GBIAS; // [RULE_03]
      ST_GBIAS:
        next_state = ST_ON; // [RULE_08]
      ST_ON:
        if (!power_on)
          next_state = ST_PARK;
      ST_PARK:
        if (park_done)
          next_state = ST_HOLD; // [RULE_09]
      ST_HOLD:
        if (hold_done)
          next_state = ST_DISCH; // [RULE_06]
      ST_DISCH:
        if (supplies_discharged)
          next_state = ST_OFF; // [RULE_05]
      ST_EMERG:
        if (!offset_power_good)
          next_state = ST_DISCH; // [RULE_10]
      default:
        next_state = ST_OFF;
    endcase
    // mirrors were never released during ramp, so no park is needed
    if (!power_on && state >= ST_CORE && state <= ST_GBIAS)
      next_state = ST_HOLD;
    if (power_loss && state == ST_CORE)
      next_state = ST_DISCH;
    else if (power_loss && state >= ST_OFFSET && state <= ST_PARK)
      next_state = ST_EMERG; // [RULE_10]
  end

  // pins decoded from the next state so each leaves a flop
  always_comb
  begin
    next_core = next_state != ST_OFF; // [RULE_05]
    next_cmos = next_state >= ST_OFFSET && next_state <= ST_PARK; // [RULE_04]
    next_offset = (next_state >= ST_OFFSET && next_state <= ST_PARK)
                  || next_state == ST_EMERG; // [RULE_10]
    next_bias = next_state >= ST_BIAS && next_state <= ST_PARK; // [RULE_03]
    next_pdn = next_state >= ST_OFFSET && next_state <= ST_PARK; // [RULE_09] [RULE_11]
    next_oen = next_state != ST_ON; // [RULE_07]
    next_gbias = next_state == ST_GBIAS; // [RULE_08]
    next_park = next_state == ST_PARK;
    otb_start = next_state == ST_OTB && state != ST_OTB;
    hold_start = next_state == ST_HOLD && state != ST_HOLD;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= ST_OFF;
      core_supply_en <= 1'b0;
      interface_supply_en <= 1'b0;
      offset_supply_en <= 1'b0;
      bias_supply_en <= 1'b0;
      mirror_reset_supply_en <= 1'b0;
      cmos_inputs_en <= 1'b0;
      power_down_n <= 1'b0;
      mirror_output_enable_n <= 1'b1;
      global_bias_cmd <= 1'b0;
      park_req <= 1'b0;
    end
    else
    begin
      state <= next_state;
      core_supply_en <= next_core;
      interface_supply_en <= next_core;
      offset_supply_en <= next_offset;
      bias_supply_en <= next_bias;
      mirror_reset_supply_en <= next_bias;
      cmos_inputs_en <= next_cmos;
      power_down_n <= next_pdn;
      mirror_output_enable_n <= next_oen;
      global_bias_cmd <= next_gbias;
      park_req <= next_park;
    end
  end

  // hardware clear of power_on on ST_EMERG beats software so a loss from ST_OFFSET to ST_PARK cannot auto-restart
  always_comb
  begin
    next_power_on = power_on;
    next_loss = loss_seen;
    if (wr_en && wr_addr == CTRL_OFS && wr_strb[0])
    begin
      next_power_on = wr_data[CTRL_ON_BIT];
      if (wr_data[CTRL_CLR_BIT])
        next_loss = 1'b0;
    end
    if (next_state == ST_EMERG)
      next_power_on = 1'b0;
    if (power_loss)
      next_loss = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      power_on <= CTRL_ON_RST;
      loss_seen <= 1'b0;
    end
    else
    begin
      power_on <= next_power_on;
      loss_seen <= next_loss;
    end
  end

  always_comb
  begin
    rd_data = '0;
    rd_err = 1'b0;
    if (rd_addr == CTRL_OFS)
      rd_data[CTRL_ON_BIT] = power_on;
    else if (rd_addr == STATUS_OFS)
    begin
      rd_data[STAT_ST_LSB +: $bits(mass_state_t)] = state;
      rd_data[STAT_LOSS_BIT] = loss_seen;
      rd_data[STAT_ON_BIT] = state == ST_ON;
    end
    else
      rd_err = 1'b1;
    wr_err = !(wr_addr == CTRL_OFS || wr_addr == STATUS_OFS);
  end

  // helper for checking: cycles offset good has been seen with offset on
  always_comb
  begin
    next_og_cnt = '0;
    if (offset_supply_en && offset_power_good)
      next_og_cnt = (og_cnt == '1) ? og_cnt : og_cnt + OG_ONE;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      og_cnt <= '0;
    else
      og_cnt <= next_og_cnt;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  property p_offset_after_core;
    $rose(offset_supply_en) |-> core_supply_en && interface_supply_en
      && $past(core_supply_good && interface_supply_good);
  endproperty
  a_offset_after_core: assert property (p_offset_after_core) // [RULE_01]
    else $error("offset rail enabled before core rails settled");

  property p_bias_after_delay;
    $rose(bias_supply_en) |-> og_cnt >= OTB_LOAD;
  endproperty
  a_bias_after_delay: assert property (p_bias_after_delay) // [RULE_02]
    else $error("bias rail enabled before offset-to-bias delay");

  property p_bias_reset_together;
    bias_supply_en == mirror_reset_supply_en;
  endproperty
  a_bias_reset_together: assert property (p_bias_reset_together) // [RULE_03]
    else $error("bias and reset enables differ");

  property p_cmos_after_settle;
    $rose(cmos_inputs_en) |-> core_supply_en
      && $past(core_supply_good && interface_supply_good);
  endproperty
  a_cmos_after_settle: assert property (p_cmos_after_settle) // [RULE_04]
    else $error("cmos inputs released before rails settled");

  property p_core_until_discharged;
    $fell(core_supply_en) |-> $past(supplies_discharged)
      && !offset_supply_en && !bias_supply_en;
  endproperty
  a_core_until_discharged: assert property (p_core_until_discharged) // [RULE_05]
    else $error("core rail dropped before discharge");

  property p_pg_hold_window;
    $fell(offset_supply_en) && state == ST_HOLD |->
      (state == ST_HOLD && core_supply_en) [*5] ##1 state == ST_DISCH;
  endproperty
  a_pg_hold_window: assert property (p_pg_hold_window) // [RULE_06]
    else $error("offset good hold window wrong length");

  property p_oe_before_enable;
    $rose(core_supply_en) |-> mirror_output_enable_n && $past(mirror_output_enable_n);
  endproperty
  a_oe_before_enable: assert property (p_oe_before_enable) // [RULE_07]
    else $error("rails enabled while output enable active");

  property p_global_bias;
    $rose(global_bias_cmd) |-> bias_supply_en && mirror_reset_supply_en
      ##1 !global_bias_cmd && (!mirror_output_enable_n || $past(power_loss || !power_on));
  endproperty
  a_global_bias: assert property (p_global_bias) // [RULE_08]
    else $error("global bias command out of place");

  property p_park_then_down;
    $fell(power_down_n) && $past(state) == ST_PARK && state == ST_HOLD |-> $past(park_done)
      && !bias_supply_en && !mirror_reset_supply_en && !offset_supply_en;
  endproperty
  a_park_then_down: assert property (p_park_then_down) // [RULE_09]
    else $error("power-down before park finished");

  property p_emerg_offset;
    $fell(offset_supply_en) && $past(state) == ST_EMERG |->
      $past(!offset_power_good) && mirror_output_enable_n;
  endproperty
  a_emerg_offset: assert property (p_emerg_offset) // [RULE_10]
    else $error("emergency offset drop out of order");

  property p_off_safe;
    state == ST_OFF |-> !core_supply_en && !offset_supply_en
      && !bias_supply_en && !power_down_n && mirror_output_enable_n;
  endproperty
  a_off_safe: assert property (p_off_safe) // [RULE_11]
    else $error("idle state with rails or signals active");

  c_reach_on: cover property (state == ST_ON);
  c_shutdown: cover property (state == ST_PARK ##[1:1000] state == ST_OFF);
  c_emergency: cover property (state == ST_EMERG ##[1:1000] state == ST_DISCH);
  c_reg_write: cover property (wr_en && wr_addr == CTRL_OFS);
endmodule : mass_seq

// ==== verilog/mass_timer.sv ====
`timescale 1ns/1ps
module mass_timer
  import mass_pkg::*;
#(
  parameter int W = TMR_W
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [W-1:0] load,
  output logic done
);
  localparam logic [W-1:0] CNT_ONE = W'(1);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_done;

  // done stays high until the next start, so a late look still sees it
  always_comb
  begin
    next_cnt = cnt;
    next_done = done;
    if (start)
    begin
      next_cnt = load;
      next_done = 1'b0;
    end
    else if (cnt != '0)
    begin
      next_cnt = cnt - CNT_ONE;
      if (cnt == CNT_ONE)
        next_done = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt <= '0;
      done <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      done <= next_done;
    end
  end
endmodule : mass_timer
